/* src/led_gs_memory.sv */
module led_gs_memory
    import led_gs_pkg::*;
#(
    parameter int UNIT_BITS = UNIT_W,
    parameter int NUM_CHANNELS = CHANNELS,
    parameter int NUM_LINES = LINES
) (
    // System clock and power-on reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Serial link, on its own clock
    input wire logic shift_clk,
    input wire logic shift_data,
    input wire logic load_strobe,
    // Display read port
    input wire logic disp_rd,
    input wire logic [4:0] disp_line,
    input wire logic [3:0] disp_channel,
    output logic disp_valid,
    output logic [UNIT_BITS-1:0] disp_unit,
    output logic [GS_W-1:0] blue_output_channel,
    output logic [GS_W-1:0] green_output_channel,
    output logic [GS_W-1:0] red_output_channel,
    // Frame and configuration state
    output logic frame_swap,
    output logic bank_sel,
    output logic [5:0] scan_lines,
    output logic [3:0] red_low_gray_compensation,
    output logic [1:0] xtalk_blue,
    output logic [1:0] xtalk_green,
    output logic [1:0] xtalk_red,
    output logic [1:0] rev_volt_blue,
    output logic [1:0] rev_volt_green,
    output logic [1:0] rev_volt_red
);

    localparam int CH_W = $clog2(NUM_CHANNELS);
    localparam int LN_W = $clog2(NUM_LINES);
    localparam int IDX_W = 1 + LN_W + CH_W;
    localparam int DEPTH = 2 * NUM_LINES * NUM_CHANNELS;

    // ========================================
    // Link domain: shift register and edge count
    // ========================================

    // Common shift register, filled MSB first
    logic [UNIT_BITS-1:0] shift_r;
    // Snapshot taken on each edge under the strobe
    logic [UNIT_BITS-1:0] hold_r;
    // Edges seen during the current strobe-high period
    logic [2:0] edge_cnt_r;
    // Strobe level at the previous link edge
    logic strobe_prev_r;
    // Shift register value after this edge
    logic [UNIT_BITS-1:0] shift_nxt;

    assign shift_nxt = {shift_r[UNIT_BITS-2:0], shift_data};

    // Shift on every edge; the strobe does not stop it
    always_ff @(posedge shift_clk or negedge rstn) begin
        if (!rstn) begin
            shift_r <= '0;
        end else begin
            shift_r <= shift_nxt;
        end
    end

    // Snapshot holds still while the strobe is low,
    // so the system side may read it at leisure
    always_ff @(posedge shift_clk or negedge rstn) begin
        if (!rstn) begin
            hold_r <= '0;
        end else if (load_strobe) begin
            hold_r <= shift_nxt; // see R14
        end
    end

    // Count edges under the strobe, restart on a new period
    always_ff @(posedge shift_clk or negedge rstn) begin
        if (!rstn) begin
            edge_cnt_r <= 3'h0;
        end else if (load_strobe) begin
            // First edge of a new strobe period
            if (!strobe_prev_r) begin
                edge_cnt_r <= 3'h1;
            // Saturate, so long bursts never alias a command
            end else if (edge_cnt_r != CMD_SAT) begin
                edge_cnt_r <= edge_cnt_r + 3'h1; // see R08
            end
        end
    end

    // Remember the strobe for period start detection
    always_ff @(posedge shift_clk or negedge rstn) begin
        if (!rstn) begin
            strobe_prev_r <= 1'b0;
        end else begin
            strobe_prev_r <= load_strobe;
        end
    end

    // ========================================
    // Strobe crossing into the system domain
    // ========================================

    // Three-stage synchroniser; stage one feeds stage two only
    logic strobe_s1_r;
    logic strobe_s2_r;
    logic strobe_s3_r;
    // Filtered strobe level
    logic strobe_lvl_r;
    // Falling edge of the filtered strobe
    logic strobe_fall;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strobe_s1_r <= 1'b0;
            strobe_s2_r <= 1'b0;
            strobe_s3_r <= 1'b0;
        end else begin
            strobe_s1_r <= load_strobe;
            strobe_s2_r <= strobe_s1_r;
            strobe_s3_r <= strobe_s2_r;
        end
    end

    // Level changes only once stages two and three agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strobe_lvl_r <= 1'b0;
        end else if (strobe_s2_r == strobe_s3_r) begin
            strobe_lvl_r <= strobe_s3_r;
        end
    end

    assign strobe_fall = strobe_lvl_r & ~strobe_s2_r & ~strobe_s3_r;

    // Command decode at the strobe's fall; count and
    // snapshot are static by then, since the link side
    // changes them only while the strobe is high
    logic wr_cmd;
    logic swap_cmd;

    assign wr_cmd = strobe_fall && (edge_cnt_r == CMD_WRITE); // see R14
    assign swap_cmd = strobe_fall && (edge_cnt_r == CMD_SWAP); // see R08

    // ========================================
    // Bank select and write counters
    // ========================================

    // Bank select flag; 0 writes bank A, shows bank B
    logic bank_sel_r;
    // Channel counter within a line
    logic [CH_W-1:0] chan_cnt_r;
    // Line write counter
    logic [LN_W-1:0] line_cnt_r;
    // One-cycle swap pulse for the display engine
    logic frame_swap_r;

    // Power-on clears; swap toggles
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bank_sel_r <= 1'b0; // see R07
        end else if (swap_cmd) begin
            bank_sel_r <= ~bank_sel_r; // see R09
        end
    end

    // Channel advances per write, clears on swap
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            chan_cnt_r <= '0;
        end else if (swap_cmd) begin
            chan_cnt_r <= '0; // see R09
        end else if (wr_cmd) begin
            chan_cnt_r <= chan_cnt_r + CH_W'(1); // see R16
        end
    end

    // Line advances after the last channel of a line
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            line_cnt_r <= '0;
        end else if (swap_cmd) begin
            line_cnt_r <= '0; // see R09
        end else if (wr_cmd && (chan_cnt_r == CH_W'(NUM_CHANNELS - 1))) begin
            line_cnt_r <= line_cnt_r + LN_W'(1); // see R16
        end
    end

    // Tell the display engine to restart its counters
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frame_swap_r <= 1'b0;
        end else begin
            frame_swap_r <= swap_cmd; // see R09
        end
    end

    // ========================================
    // Display memory, two banks in flip-flops
    // ========================================

    // Index is {bank, line, channel}; bank 0 is bank A
    logic [UNIT_BITS-1:0] mem [0:DEPTH-1]; // see R05
    logic [IDX_W-1:0] wr_idx;
    logic [IDX_W-1:0] rd_idx;

    assign wr_idx = {bank_sel_r, line_cnt_r, chan_cnt_r}; // see R16
    assign rd_idx = {~bank_sel_r, disp_line[LN_W-1:0], disp_channel[CH_W-1:0]}; // see R06

    // No reset: contents are undefined until written
    always_ff @(posedge clk) begin
        if (wr_cmd) begin
            mem[wr_idx] <= hold_r; // see R11
        end
    end

    // ========================================
    // Configuration register
    // ========================================

    logic [4:0] max_line_r;
    logic [3:0] rlgc_r;
    logic [1:0] xt_b_r;
    logic [1:0] rv_b_r;
    logic [1:0] xt_g_r;
    logic [1:0] rv_g_r;
    logic [1:0] xt_r_r;
    logic [1:0] rv_r_r;

    // Low word: scan lines and red compensation
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            max_line_r <= MAX_LINE_RST;
            rlgc_r <= RLGC_RST;
        end else if (reg_wr && (reg_addr == OFS_CFG_LO)) begin
            max_line_r <= reg_wdata[MAX_LINE_LSB +: 5]; // see R04
            rlgc_r <= reg_wdata[RLGC_LSB +: 4]; // see R01
        end
    end

    // High word: crosstalk and reverse-voltage fields
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xt_b_r <= FIELD2_RST;
            rv_b_r <= FIELD2_RST;
            xt_g_r <= FIELD2_RST;
            rv_g_r <= FIELD2_RST;
            xt_r_r <= FIELD2_RST;
            rv_r_r <= FIELD2_RST;
        end else if (reg_wr && (reg_addr == OFS_CFG_HI)) begin
            xt_b_r <= reg_wdata[XT_B_LSB +: 2]; // see R02
            rv_b_r <= reg_wdata[RV_B_LSB +: 2]; // see R03
            xt_g_r <= reg_wdata[XT_G_LSB +: 2]; // see R02
            rv_g_r <= reg_wdata[RV_G_LSB +: 2]; // see R03
            xt_r_r <= reg_wdata[XT_R_LSB +: 2]; // see R02
            rv_r_r <= reg_wdata[RV_R_LSB +: 2]; // see R03
        end
    end

    // ========================================
    // Register read port
    // ========================================

    logic [31:0] rd_word;
    logic [31:0] reg_rdata_r;

    // Unused bits and unmapped offsets read as zero
    always_comb begin
        rd_word = 32'h0;
        case (reg_addr)
            OFS_CFG_LO: begin
                rd_word[MAX_LINE_LSB +: 5] = max_line_r;
                rd_word[RLGC_LSB +: 4] = rlgc_r;
            end
            OFS_CFG_HI: begin
                rd_word[XT_B_LSB +: 2] = xt_b_r;
                rd_word[RV_B_LSB +: 2] = rv_b_r;
                rd_word[XT_G_LSB +: 2] = xt_g_r;
                rd_word[RV_G_LSB +: 2] = rv_g_r;
                rd_word[XT_R_LSB +: 2] = xt_r_r;
                rd_word[RV_R_LSB +: 2] = rv_r_r;
            end
            OFS_STATUS: begin
                rd_word[ST_BANK_BIT] = bank_sel_r;
                rd_word[ST_CHAN_LSB +: CH_W] = chan_cnt_r;
                rd_word[ST_LINE_LSB +: LN_W] = line_cnt_r;
            end
            default: begin
                rd_word = 32'h0;
            end
        endcase
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_r <= 32'h0;
        end else if (reg_rd) begin
            reg_rdata_r <= rd_word;
        end else begin
            reg_rdata_r <= 32'h0;
        end
    end

    // ========================================
    // Display read port
    // ========================================

    logic line_in_range;
    logic [UNIT_BITS-1:0] disp_unit_r;
    logic disp_valid_r;

    // Lines past the configured count are not shown
    assign line_in_range = ({1'b0, disp_line} <= {1'b0, max_line_r}); // see R17

    // Registered read of the display bank
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            disp_unit_r <= '0;
        end else if (disp_rd) begin
            // Blank unit outside the scanned lines
            disp_unit_r <= line_in_range ? mem[rd_idx] : '0; // see R17
        end
    end

    // Valid marks a read inside the scanned lines
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            disp_valid_r <= 1'b0;
        end else begin
            disp_valid_r <= disp_rd && line_in_range;
        end
    end

    // ========================================
    // Outputs
    // ========================================

    assign reg_rdata = reg_rdata_r;
    assign disp_unit = disp_unit_r;
    assign disp_valid = disp_valid_r;
    // Colour split of one unit
    assign blue_output_channel = disp_unit_r[BLUE_LSB +: GS_W]; // see R12
    assign green_output_channel = disp_unit_r[GREEN_LSB +: GS_W]; // see R12
    assign red_output_channel = disp_unit_r[RED_LSB +: GS_W]; // see R12
    assign frame_swap = frame_swap_r;
    assign bank_sel = bank_sel_r;
    // Field value plus one gives 1 to 32 lines
    assign scan_lines = {1'b0, max_line_r} + 6'h01; // see R04
    assign red_low_gray_compensation = rlgc_r;
    assign xtalk_blue = xt_b_r;
    assign xtalk_green = xt_g_r;
    assign xtalk_red = xt_r_r;
    assign rev_volt_blue = rv_b_r;
    assign rev_volt_green = rv_g_r;
    assign rev_volt_red = rv_r_r;

endmodule

/* inc/led_gs_pkg.sv */
// What this block does
// (R01) Four-bit red low-gray compensation, zero means none
// (R02) Per-colour crosstalk fields, two bits, reset 00
// (R03) Per-colour reverse-voltage fields, two bits, reset 00
// (R04) Scan lines equal five-bit field plus one
// (R05) Memory covers one to thirty-two scan lines
// (R06) Two banks: one displayed, one written
// (R07) Power-on clears bank select: write A, show B
// (R08) Three shift edges under strobe mean swap
// (R09) Swap toggles bank select, clears line and channel counters
// (R10) Host issues swap once per frame period
// (R11) Bank: 32 lines of 16 units, 48 bits
// (R12) Unit holds blue 47:32, green 31:16, red 15:0
// (R13) Host writes 16 units per configured line
// (R14) One edge under strobe writes one unit
// (R15) Host shifts blue bit 15 first
// (R16) Target unit from bank, line and channel counters
// (R17) Lines beyond scan count read as blank
package led_gs_pkg;

    // ========================================
    // Memory geometry
    localparam int UNIT_W = 48;
    localparam int CHANNELS = 16;
    localparam int LINES = 32;
    localparam int GS_W = 16;
    localparam int BLUE_LSB = 32;
    localparam int GREEN_LSB = 16;
    localparam int RED_LSB = 0;

    // ========================================
    // Commands, as shift edges under the strobe
    localparam logic [2:0] CMD_WRITE = 3'h1;
    localparam logic [2:0] CMD_SWAP = 3'h3;
    localparam logic [2:0] CMD_SAT = 3'h7;

    // ========================================
    // Register offsets (byte addresses)
    localparam logic [3:0] OFS_CFG_LO = 4'h0;
    localparam logic [3:0] OFS_CFG_HI = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;

    // ========================================
    // Configuration field positions
    localparam int MAX_LINE_LSB = 0;
    localparam int RLGC_LSB = 28;
    localparam int XT_B_LSB = 0;
    localparam int RV_B_LSB = 2;
    localparam int XT_G_LSB = 4;
    localparam int RV_G_LSB = 6;
    localparam int XT_R_LSB = 8;
    localparam int RV_R_LSB = 10;

    // ========================================
    // Reset values
    localparam logic [4:0] MAX_LINE_RST = 5'h1F;
    localparam logic [3:0] RLGC_RST = 4'h0;
    localparam logic [1:0] FIELD2_RST = 2'h0;

    // ========================================
    // Status field positions
    localparam int ST_BANK_BIT = 0;
    localparam int ST_CHAN_LSB = 8;
    localparam int ST_LINE_LSB = 16;

endpackage

/* sim/led_gs_memory_checker.sv */
module led_gs_memory_checker
    import led_gs_pkg::*;
#(
    parameter int UNIT_BITS = UNIT_W
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic disp_rd,
    input wire logic [4:0] disp_line,
    input wire logic disp_valid,
    input wire logic [UNIT_BITS-1:0] disp_unit,
    input wire logic [GS_W-1:0] blue_output_channel,
    input wire logic [GS_W-1:0] red_output_channel,
    input wire logic frame_swap,
    input wire logic bank_sel,
    input wire logic [5:0] scan_lines,
    input wire logic [3:0] red_low_gray_compensation,
    input wire logic [1:0] xtalk_blue,
    input wire logic [1:0] rev_volt_red
);
    timeunit 1ns;
    timeprecision 1ns;

    // ====
    // Everything here is on the system clock
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_red_comp: assert property (reg_wr && reg_addr == OFS_CFG_LO
        |=> red_low_gray_compensation == $past(reg_wdata[31:28])) else $error("red comp not loaded");
    a_field_load: assert property (reg_wr && reg_addr == OFS_CFG_HI
        |=> {rev_volt_red, xtalk_blue} == {$past(reg_wdata[11:10]), $past(reg_wdata[1:0])})
        else $error("field not loaded");
    a_scan_count: assert property (reg_wr && reg_addr == OFS_CFG_LO
        |=> scan_lines == {1'b0, $past(reg_wdata[4:0])} + 6'h01) else $error("scan count wrong");
    a_swap_flag: assert property ($changed(bank_sel) |-> ##[0:2] frame_swap)
        else $error("bank flip without swap pulse");
    a_swap_once: assert property (frame_swap |=> !frame_swap [*8])
        else $error("swap pulse too long");
    a_line_shown: assert property (disp_rd && {1'b0, disp_line} < scan_lines |=> disp_valid)
        else $error("active line not shown");
    a_line_blank: assert property (disp_rd && {1'b0, disp_line} >= scan_lines
        |=> !disp_valid && disp_unit == '0) else $error("line beyond count shown");
    a_unit_hold: assert property (!disp_rd |=> $stable(disp_unit))
        else $error("unit changed without read");
    a_colour_split: assert property ({blue_output_channel, red_output_channel}
        == {disp_unit[BLUE_LSB+:GS_W], disp_unit[RED_LSB+:GS_W]}) else $error("colour slices wrong");
endmodule

bind led_gs_memory led_gs_memory_checker #(.UNIT_BITS(UNIT_BITS)) chk (
    .clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .disp_rd, .disp_line, .disp_valid, .disp_unit,
    .blue_output_channel, .red_output_channel, .frame_swap, .bank_sel, .scan_lines,
    .red_low_gray_compensation, .xtalk_blue, .rev_volt_red
);

/* sim/led_host_model.sv */
module led_host_model (
    output logic shift_clk,
    output logic shift_data,
    output logic load_strobe
);
    timeunit 1ns;
    timeprecision 1ns;

    // ====
    // Link clock rests low outside frames
    initial begin
        shift_clk = 1'b0;
        shift_data = 1'b0;
        load_strobe = 1'b0;
    end

    // One 160 ns link clock period
    task automatic pulse();
        #80 shift_clk = 1'b1;
        #80 shift_clk = 1'b0;
    endtask

    // Blue bit 15 first; the last n edges fall under the strobe
    task automatic send(input logic [47:0] u, input int n);
        #13;
        for (int i = 47; i >= 0; i--) begin
            shift_data = u[i];
            if (i == n - 1) begin
                load_strobe = 1'b1;
            end
            pulse();
        end
        load_strobe = 1'b0;
        // Idle data flips, so a stale bit never passes as fresh
        shift_data = ~shift_data;
        #480;
    endtask
endmodule

/* sim/led_driver_dual_bank_gs_memory_bench.sv */
module led_driver_dual_bank_gs_memory_bench
    import led_gs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ====
    // Stimulus and observed signals
    logic clk, rstn, reg_wr, reg_rd, disp_rd, disp_valid, frame_swap, bank_sel;
    logic [3:0] reg_addr, disp_channel, red_low_gray_compensation;
    logic [31:0] reg_wdata, reg_rdata;
    logic [4:0] disp_line;
    logic [47:0] disp_unit;
    logic [15:0] blue_output_channel, green_output_channel, red_output_channel;
    logic [5:0] scan_lines;
    logic [1:0] xtalk_blue, xtalk_green, xtalk_red, rev_volt_blue, rev_volt_green, rev_volt_red;
    wire logic shift_clk, shift_data, load_strobe;
    int mismatches, checked, swaps;

    led_gs_memory dut (
        .clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .shift_clk, .shift_data,
        .load_strobe, .disp_rd, .disp_line, .disp_channel, .disp_valid, .disp_unit, .blue_output_channel,
        .green_output_channel, .red_output_channel, .frame_swap, .bank_sel, .scan_lines,
        .red_low_gray_compensation, .xtalk_blue, .xtalk_green, .xtalk_red, .rev_volt_blue,
        .rev_volt_green, .rev_volt_red
    );
    led_host_model host (.shift_clk, .shift_data, .load_strobe);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Swap pulses are one cycle wide, so count them as they pass
    always @(posedge clk) begin
        if (frame_swap === 1'b1) begin
            swaps++;
        end
    end

    // ====
    // Shared helpers
    task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(what, 48'(exp), 48'(reg_rdata));
        // Data must fall back to zero one cycle later
        @(posedge clk);
        #1 check({what, "_after"}, 48'h0, 48'(reg_rdata));
    endtask

    task automatic show(input logic [4:0] ln, input logic [3:0] ch, input logic [47:0] exp, input logic ok);
        @(posedge clk);
        disp_rd <= 1'b1;
        disp_line <= ln;
        disp_channel <= ch;
        @(posedge clk);
        disp_rd <= 1'b0;
        #1 check("disp_valid", 48'(ok), 48'(disp_valid));
        check("disp_unit", exp, disp_unit);
        check("colours", exp, {blue_output_channel, green_output_channel, red_output_channel});
    endtask

    // Distinct colour values per unit
    function automatic logic [47:0] uv(input int i);
        return 48'hB000_6000_A000 + {3{16'(i)}};
    endfunction

    function automatic logic [31:0] st(input int ln, input int ch, input logic b);
        return {11'h000, 5'(ln), 4'h0, 4'(ch), 7'h00, b};
    endfunction

    // ====
    // Scenarios
    task automatic t_reset();
        check("bank_sel", 48'h0, 48'(bank_sel));
        check("scan_lines", 48'h20, 48'(scan_lines));
        check("red_comp", 48'h0, 48'(red_low_gray_compensation));
        check("fields", 48'h0, 48'({xtalk_blue, xtalk_green, xtalk_red, rev_volt_blue, rev_volt_green,
            rev_volt_red}));
        rd(OFS_STATUS, 32'h0000_0000, "status");
    endtask

    // Each field walks all four codes, never equal to its neighbours
    task automatic t_config();
        logic [11:0] f;
        for (int v = 0; v < 4; v++) begin
            f = 12'h1B4 ^ {6{2'(v)}};
            wr(OFS_CFG_HI, {20'h00000, f});
            check("fields", 48'(f), 48'({rev_volt_red, xtalk_red, rev_volt_green, xtalk_green, rev_volt_blue,
                xtalk_blue}));
            rd(OFS_CFG_HI, {20'h00000, f}, "cfg_hi");
        end
        wr(OFS_CFG_LO, 32'hF000_0000);
        check("scan_lines", 48'h1, 48'(scan_lines));
        check("red_comp", 48'hF, 48'(red_low_gray_compensation));
        wr(OFS_CFG_LO, 32'h0000_001F);
        rd(OFS_CFG_LO, 32'h0000_001F, "cfg_lo");
        wr(4'hC, 32'hFFFF_FFFF);
        rd(4'hC, 32'h0000_0000, "unmapped");
    endtask

    // Seventeen units cross into the second line before the swap
    task automatic t_frame();
        for (int i = 0; i < 17; i++) begin
            host.send(uv(i), 1);
        end
        rd(OFS_STATUS, st(1, 1, 1'b0), "counters");
        host.send(48'h0, 3);
        check("swaps", 48'h1, 48'(swaps));
        rd(OFS_STATUS, st(0, 0, 1'b1), "cleared");
        show(5'h00, 4'h0, uv(0), 1'b1);
        show(5'h00, 4'hF, uv(15), 1'b1);
        show(5'h01, 4'h0, uv(16), 1'b1);
        host.send(uv(9), 2);
        rd(OFS_STATUS, st(0, 0, 1'b1), "ignored");
    endtask

    // One scan line: the second line reads blank
    task automatic t_scan();
        wr(OFS_CFG_LO, 32'h0000_0000);
        show(5'h01, 4'h0, 48'h0, 1'b0);
        show(5'h00, 4'h1, uv(1), 1'b1);
        wr(OFS_CFG_LO, 32'h0000_001F);
        host.send(48'h0, 3);
        check("bank_sel", 48'h0, 48'(bank_sel));
        check("swaps", 48'h2, 48'(swaps));
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        {reg_wr, reg_rd, disp_rd, reg_addr, reg_wdata, disp_line, disp_channel} = '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        #1 t_reset();
        t_config();
        t_frame();
        t_scan();
        conclude();
    end

    // About 166 us of traffic expected
    initial begin
        #1_000_000;
        mismatches++;
        conclude();
    end
endmodule
